/* File: include/ath_pkg.sv */
/*
  shared constants, register map and carrier types of the auxiliary
  trigger handshake block.
  assumes a 100 MHz core clock and a same-clock measurement engine.
*/
package ath_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int BTN_MIN_NS = 1000;
  localparam int BTN_MIN_CYC = (BTN_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam longint BTN_PRESS_MAX_NS = 64'd2000000000;
  localparam int BTN_PRESS_MAX_CYC = int'(BTN_PRESS_MAX_NS / CLK_NS);
  localparam longint BTN_HARD_NS = 64'd4000000000;
  localparam int BTN_HARD_CYC = int'((BTN_HARD_NS + CLK_NS - 1) / CLK_NS);
  localparam int BTN_CNT_W = 32;

  // ----------------------------------------------------------------
  // widths and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int DAC_W = 12;
  localparam int DAC_N = 2;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_DAC1 = 4'h1;
  localparam logic [ADDR_W-1:0] REG_DAC2 = 4'h2;
  localparam logic [ADDR_W-1:0] REG_DACO1 = 4'h3;
  localparam logic [ADDR_W-1:0] REG_DACO2 = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'h5;
  localparam logic [ADDR_W-1:0] REG_PRESET = 4'h6;
  localparam int CTRL_W = 5;
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_PRESS_BIT = 1;
  localparam int STAT_HARD_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam int PRESET_BIT = 0;
  localparam logic [DAC_W-1:0] DAC_ZERO = 12'h800;
  localparam logic POL_RST = 1'b1;
  localparam logic EXT_RST = 1'b0;
  localparam logic SINGLE_RST = 1'b0;

  // ----------------------------------------------------------------
  // synchroniser lanes
  // ----------------------------------------------------------------
  localparam int SYNC_W = 2;
  localparam int SYNC_TRIG = 0;
  localparam int SYNC_BTN = 1;
  localparam logic [SYNC_W-1:0] SYNC_RST = 2'h3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SCOPE_POINT = 2'h0,
    SCOPE_CHAN = 2'h1,
    SCOPE_GLOBAL = 2'h2
  } ath_scope_t;

  typedef struct packed {
    logic single;
    ath_scope_t scope;
    logic pol_high;
    logic ext_mode;
  } ath_ctrl_t;

  typedef enum logic [2:0] {
    ST_WAIT = 3'h0,
    ST_READY = 3'h1,
    ST_RANGE = 3'h3,
    ST_ACQ = 3'h2,
    ST_ADV = 3'h6
  } ath_seq_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ath_bus_req_t;

  typedef struct packed {
    logic meas_idle;
    logic src_ready;
    logic point_ready;
    logic range_done;
    logic acq_done;
    logic adv_done;
    logic retrace;
    logic presweep;
  } ath_eng_in_t;

  typedef struct packed {
    logic range_go;
    logic acq_go;
    logic adv_go;
    ath_scope_t scope;
  } ath_eng_out_t;

endpackage

/* File: src/ath_sync2.sv */
/*
  two-flop synchroniser for the trigger and power button pins.
  assumes both pins idle high through their pull-ups.
*/
module ath_sync2 (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  // pins and synchronised levels
  input wire logic [ath_pkg::SYNC_W-1:0] async_in,
  output logic [ath_pkg::SYNC_W-1:0] sync_out
);
  import ath_pkg::*;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
  } ath_sync_st_t;

  ath_sync_st_t r, n;

  always_comb begin
    n = r;
    if (ce) begin
      n.s1 = async_in;
      n.s2 = r.s1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      r <= {SYNC_RST, SYNC_RST};
    end else begin
      r <= n;
    end
  end

  assign sync_out = r.s2;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_sync_lat;
    ($past(ce) && $past(ce, 2) && $past(resetn) && $past(resetn, 2))
      |-> sync_out == $past(async_in, 2);
  endproperty
  a_sync_lat: assert property (p_sync_lat)
    else $error("synchroniser latency is not two enabled edges");

endmodule

/* File: src/ath_btn_timer.sv */
/*
  power button low-time counter: short press and hard reset decode.
  assumes a synchronised button-low level, high while the button is held.
*/
module ath_btn_timer #(
  parameter int PRESS_MAX_CYC = ath_pkg::BTN_PRESS_MAX_CYC,
  parameter int HARD_CYC = ath_pkg::BTN_HARD_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  // button level and decoded events
  input wire logic btn_low,
  output logic press,
  output logic hard_rst
);
  import ath_pkg::*;

  typedef struct packed {
    logic [BTN_CNT_W-1:0] cnt;
    logic press;
    logic hard;
  } ath_btn_st_t;

  localparam logic [BTN_CNT_W-1:0] MIN_C = BTN_CNT_W'(BTN_MIN_CYC);
  localparam logic [BTN_CNT_W-1:0] MAX_C = BTN_CNT_W'(PRESS_MAX_CYC);
  localparam logic [BTN_CNT_W-1:0] HARD_C = BTN_CNT_W'(HARD_CYC);

  ath_btn_st_t r, n;

  always_comb begin
    n = r;
    if (ce) begin
      n.press = 1'b0;
      n.hard = 1'b0;
      if (btn_low) begin
        // saturates one past the hard limit
        if (r.cnt <= HARD_C) begin
          n.cnt = r.cnt + BTN_CNT_W'(1);
        end
        if (r.cnt == HARD_C) begin
          n.hard = 1'b1;
        end
      end else begin
        if (r.cnt >= MIN_C && r.cnt <= MAX_C) begin
          n.press = 1'b1;
        end
        n.cnt = '0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign press = r.press;
  assign hard_rst = r.hard;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_press_len;
    (r.press && $past(ce)) |-> !$past(btn_low) && $past(r.cnt) >= MIN_C
      && $past(r.cnt) <= MAX_C;
  endproperty
  a_press_len: assert property (p_press_len)
    else $error("press reported for a bad low time");

  property p_hard_len;
    (r.hard && $past(ce)) |-> $past(btn_low) && $past(r.cnt) == HARD_C;
  endproperty
  a_hard_len: assert property (p_hard_len)
    else $error("hard reset at the wrong low time");

  property p_cnt_clear;
    (ce && !btn_low) |=> r.cnt == '0;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear)
    else $error("low-time counter not cleared on release");

  c_press: cover property (r.press);

endmodule

/* File: src/ath_aux_trig.sv */
/*
  auxiliary port trigger handshake, analog-output update timing and
  power button decode, with a small register port.
  assumes a same-clock measurement engine that answers each go pulse
  with its done level or pulse, and raw asynchronous pins.
*/
module ath_aux_trig #(
  parameter int PRESS_MAX_CYC = ath_pkg::BTN_PRESS_MAX_CYC,
  parameter int HARD_CYC = ath_pkg::BTN_HARD_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  // register port
  input wire ath_pkg::ath_bus_req_t bus_req,
  output logic [ath_pkg::DATA_W-1:0] reg_rdata,
  // measurement engine
  input wire ath_pkg::ath_eng_in_t eng_in,
  output ath_pkg::ath_eng_out_t eng_out,
  // rear panel pins
  input wire logic ext_trig_pin,
  input wire logic pwr_btn_n_pin,
  output logic trig_ready_n,
  // converter codes
  output logic [ath_pkg::DAC_W-1:0] dac1_code,
  output logic [ath_pkg::DAC_W-1:0] dac2_code,
  // power button events
  output logic btn_press,
  output logic hard_reset
);
  import ath_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    ath_seq_t seq;
    ath_ctrl_t ctrl;
    logic [DAC_N-1:0][DAC_W-1:0] dac_stg;
    logic [DAC_N-1:0][DAC_W-1:0] dac_out;
    logic press_seen;
    logic hard_seen;
    logic rdy_n;
    logic range_go;
    logic acq_go;
    logic adv_go;
    logic [DATA_W-1:0] rdata;
  } ath_main_st_t;

  ath_main_st_t r, n;
  logic [SYNC_W-1:0] pins_s;
  logic trig_lvl;
  logic trig_on;
  logic press_ev;
  logic hard_ev;
  logic do_preset;
  logic dac_apply;

  // ----------------------------------------------------------------
  // pin synchronisers and button timer
  // ----------------------------------------------------------------
  ath_sync2 u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .ce(ce),
    .async_in({pwr_btn_n_pin, ext_trig_pin}),
    .sync_out(pins_s)
  );

  ath_btn_timer #(
    .PRESS_MAX_CYC(PRESS_MAX_CYC),
    .HARD_CYC(HARD_CYC)
  ) u_btn (
    .core_clk(core_clk),
    .resetn(resetn),
    .ce(ce),
    .btn_low(!pins_s[SYNC_BTN]),
    .press(press_ev),
    .hard_rst(hard_ev)
  );

  assign trig_lvl = pins_s[SYNC_TRIG];
  // asserted level compare, no edge detect
  assign trig_on = (trig_lvl == r.ctrl.pol_high);
  assign do_preset = bus_req.wr && bus_req.addr == REG_PRESET
    && bus_req.wdata[PRESET_BIT];
  assign dac_apply = r.ctrl.single ? eng_in.presweep
    : eng_in.retrace;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.range_go = 1'b0;
    n.acq_go = 1'b0;
    n.adv_go = 1'b0;
    n.rdata = '0;
    if (ce) begin
      // register reads
      if (bus_req.rd) begin
        case (bus_req.addr)
          REG_CTRL: n.rdata = DATA_W'(r.ctrl);
          REG_DAC1: n.rdata = DATA_W'(r.dac_stg[0]);
          REG_DAC2: n.rdata = DATA_W'(r.dac_stg[1]);
          REG_DACO1: n.rdata = DATA_W'(r.dac_out[0]);
          REG_DACO2: n.rdata = DATA_W'(r.dac_out[1]);
          REG_STAT: begin
            n.rdata[STAT_READY_BIT] = !r.rdy_n;
            n.rdata[STAT_PRESS_BIT] = r.press_seen;
            n.rdata[STAT_HARD_BIT] = r.hard_seen;
            n.rdata[STAT_BUSY_BIT] = r.seq != ST_WAIT
              && r.seq != ST_READY;
            n.press_seen = 1'b0;
            n.hard_seen = 1'b0;
          end
          default: n.rdata = '0;
        endcase
      end
      // register writes
      if (bus_req.wr) begin
        case (bus_req.addr)
          REG_CTRL: n.ctrl = ath_ctrl_t'(bus_req.wdata[CTRL_W-1:0]);
          REG_DAC1: n.dac_stg[0] = bus_req.wdata[DAC_W-1:0];
          REG_DAC2: n.dac_stg[1] = bus_req.wdata[DAC_W-1:0];
          default: n.ctrl = n.ctrl;
        endcase
      end
      // converter update point in the sweep
      if (dac_apply) begin
        n.dac_out = r.dac_stg;
      end
      // preset: internal trigger, zero-volt converters
      if (do_preset) begin
        n.ctrl.ext_mode = 1'b0;
        for (int i = 0; i < DAC_N; i++) begin
          n.dac_stg[i] = DAC_ZERO;
          n.dac_out[i] = DAC_ZERO;
        end
      end
      // sticky button events, set wins over read clear
      if (press_ev) begin
        n.press_seen = 1'b1;
      end
      if (hard_ev) begin
        n.hard_seen = 1'b1;
      end
      // trigger sequencer
      case (r.seq)
        ST_WAIT: begin
          if (r.ctrl.ext_mode && eng_in.meas_idle && eng_in.src_ready
              && eng_in.point_ready) begin
            n.seq = ST_READY;
          end
        end
        ST_READY: begin
          if (!r.ctrl.ext_mode) begin
            n.seq = ST_WAIT;
          end else if (trig_on) begin
            n.seq = ST_RANGE;
            n.range_go = 1'b1;
          end
        end
        ST_RANGE: begin
          if (eng_in.range_done) begin
            n.seq = ST_ACQ;
            n.acq_go = 1'b1;
          end
        end
        ST_ACQ: begin
          if (eng_in.acq_done) begin
            n.seq = ST_ADV;
            n.adv_go = 1'b1;
          end
        end
        ST_ADV: begin
          if (eng_in.adv_done) begin
            n.seq = ST_WAIT;
          end
        end
        default: n.seq = ST_WAIT;
      endcase
      // ready low only in the ready state with external mode on
      n.rdy_n = !(n.seq == ST_READY && n.ctrl.ext_mode);
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      r.seq <= ST_WAIT;
      r.ctrl.single <= SINGLE_RST;
      r.ctrl.scope <= SCOPE_GLOBAL;
      r.ctrl.pol_high <= POL_RST;
      r.ctrl.ext_mode <= EXT_RST;
      r.dac_stg <= {DAC_N{DAC_ZERO}};
      r.dac_out <= {DAC_N{DAC_ZERO}};
      r.press_seen <= 1'b0;
      r.hard_seen <= 1'b0;
      r.rdy_n <= 1'b1;
      r.range_go <= 1'b0;
      r.acq_go <= 1'b0;
      r.adv_go <= 1'b0;
      r.rdata <= '0;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = r.rdata;
  assign trig_ready_n = r.rdy_n;
  assign eng_out.range_go = r.range_go;
  assign eng_out.acq_go = r.acq_go;
  assign eng_out.adv_go = r.adv_go;
  assign eng_out.scope = r.ctrl.scope;
  assign dac1_code = r.dac_out[0];
  assign dac2_code = r.dac_out[1];
  assign btn_press = press_ev;
  assign hard_reset = hard_ev;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_rdy_ext;
    !r.ctrl.ext_mode |-> trig_ready_n;
  endproperty
  a_rdy_ext: assert property (p_rdy_ext)
    else $error("ready low outside external mode");

  property p_ack;
    (ce && r.seq == ST_READY && r.ctrl.ext_mode && trig_on
      && !bus_req.wr) |=> trig_ready_n && eng_out.range_go;
  endproperty
  a_ack: assert property (p_ack)
    else $error("accepted trigger did not raise ready and start range");

  property p_rdy_cond;
    $fell(trig_ready_n) |-> $past(eng_in.meas_idle && eng_in.src_ready
      && eng_in.point_ready);
  endproperty
  a_rdy_cond: assert property (p_rdy_cond)
    else $error("ready went low before the engine was ready");

  property p_ignore;
    (ce && trig_ready_n) |=> !eng_out.range_go;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("trigger taken while not ready");

  property p_order;
    (ce && r.seq == ST_RANGE && eng_in.range_done) |=> eng_out.acq_go
      ##0 (r.seq == ST_ACQ);
  endproperty
  a_order: assert property (p_order)
    else $error("acquire did not follow autorange");

  property p_preset;
    (ce && do_preset && !dac_apply) |=> !r.ctrl.ext_mode
      && dac1_code == DAC_ZERO && dac2_code == DAC_ZERO && trig_ready_n;
  endproperty
  a_preset: assert property (p_preset)
    else $error("preset did not restore trigger source and converters");

  property p_dac_hold;
    (ce && !dac_apply && !do_preset) |=> $stable(r.dac_out);
  endproperty
  a_dac_hold: assert property (p_dac_hold)
    else $error("converter code changed outside its update point");

  property p_dac_apply;
    (ce && dac_apply && !do_preset) |=> r.dac_out == $past(r.dac_stg);
  endproperty
  a_dac_apply: assert property (p_dac_apply)
    else $error("converter code not applied at its update point");

  property p_readback;
    (ce && bus_req.rd && bus_req.addr == REG_DAC1) |=>
      reg_rdata == DATA_W'($past(r.dac_stg[0]));
  endproperty
  a_readback: assert property (p_readback)
    else $error("converter code read back wrong");

  c_trig: cover property (eng_out.range_go);
  c_retrig: cover property (eng_out.range_go ##[1:200] eng_out.range_go);
  c_apply: cover property (ce && dac_apply && r.ctrl.single);
  c_preset: cover property (ce && do_preset);

endmodule

/* File: bench/ath_trig_src.sv */
/*
  far-side trigger source model: drives the external trigger pin.
  assumes the bench mirrors the programmed asserted level on pol_high.
*/
module ath_trig_src (
  // clock
  input wire logic core_clk,
  // asserted level and pin
  input wire logic pol_high,
  output logic ext_trig_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic act = 1'b0;

  // ----------------------------------------------------------------
  // pin drive, deasserted level outside pulses
  // ----------------------------------------------------------------
  assign ext_trig_pin = act ? pol_high : !pol_high;

  // one pulse of cyc core cycles, 100 to 5000 for a single trigger
  task automatic pulse(input int cyc);
    @(posedge core_clk);
    act <= 1'b1;
    repeat (cyc) @(posedge core_clk);
    act <= 1'b0;
  endtask

  // continuous assertion for repeated triggering
  task automatic hold(input logic on);
    @(posedge core_clk);
    act <= on;
  endtask
endmodule

/* File: bench/ath_aux_trig_tb.sv */
/*
  self-checking bench of the auxiliary trigger handshake block.
  assumes shortened button limits and an engine answering each go
  pulse with a done pulse one cycle later.
*/
module ath_aux_trig_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ath_pkg::*;

  logic core_clk = 0, resetn = 0, pol = 1, btn_n = 1, trig, rdy_n;
  logic ce = 1;
  logic press, hard;
  ath_bus_req_t bus_req = '0;
  ath_eng_in_t eng_in = '0;
  ath_eng_out_t eng_out;
  logic [DATA_W-1:0] reg_rdata, d;
  logic [DAC_W-1:0] dac1, dac2, r;
  int error_cnt = 0, checks_done = 0, n_rng = 0, n_prs = 0, n_hrd = 0;
  int n0, p0, h0, last = 3;
  int bl[4] = '{50, 300, 990, 2100};
  int bp[4] = '{0, 1, 1, 0};

  always #5 core_clk = ~core_clk;

  ath_aux_trig #(.PRESS_MAX_CYC(1000), .HARD_CYC(2000)) DUT (
    .core_clk(core_clk), .resetn(resetn), .ce(ce),
    .bus_req(bus_req), .reg_rdata(reg_rdata),
    .eng_in(eng_in), .eng_out(eng_out),
    .ext_trig_pin(trig), .pwr_btn_n_pin(btn_n),
    .trig_ready_n(rdy_n), .dac1_code(dac1), .dac2_code(dac2),
    .btn_press(press), .hard_reset(hard));

  ath_trig_src src (.core_clk(core_clk), .pol_high(pol),
    .ext_trig_pin(trig));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] e,
      input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [15:0] ctrl(input int s, c, p, e);
    return 16'((s << 4) | (c << 2) | (p << 1) | e);
  endfunction

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk);
    bus_req.wr <= 1'b1;
    bus_req.addr <= a;
    bus_req.wdata <= v;
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge core_clk);
    bus_req.rd <= 1'b1;
    bus_req.addr <= a;
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic wait_rdy(input logic v);
    int i;
    i = 0;
    while (rdy_n !== v && i < 50) begin
      @(posedge core_clk);
      #1 i++;
    end
    chk("trig_ready_n", 16'(v), 16'(rdy_n));
  endtask

  task automatic sweep(input logic rt, input logic ps);
    @(posedge core_clk);
    eng_in.retrace <= rt;
    eng_in.presweep <= ps;
    @(posedge core_clk);
    eng_in.retrace <= 1'b0;
    eng_in.presweep <= 1'b0;
    #1;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // engine answers and event counters
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    eng_in.range_done <= eng_out.range_go;
    eng_in.acq_done <= eng_out.acq_go;
    eng_in.adv_done <= eng_out.adv_go;
    if (eng_out.range_go === 1'b1) begin
      n_rng++;
      chk("step order", 3, 16'(last));
      last = 1;
    end
    if (eng_out.acq_go === 1'b1) begin
      chk("step order", 1, 16'(last));
      last = 2;
    end
    if (eng_out.adv_go === 1'b1) begin
      chk("step order", 2, 16'(last));
      last = 3;
    end
    if (press === 1'b1) n_prs++;
    if (hard === 1'b1) n_hrd++;
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    void'($urandom(44998));
    @(posedge core_clk);
    #1 chk("trig_ready_n", 1, 16'(rdy_n));
    chk("dac1_code", DAC_ZERO, 16'(dac1));
    rd(REG_CTRL, d);
    chk("ctrl", ctrl(0, 2, 1, 0), d);
    rd(4'hf, d);
    chk("unmapped", 0, d);
    $display("test reset done");
    n0 = n_rng;
    src.pulse(200);
    #1 chk("trig_ready_n", 1, 16'(rdy_n));
    chk("range_go count", 16'(n0), 16'(n_rng));
    for (int s = 0; s < 3; s++) begin
      wr(REG_CTRL, ctrl(0, s, 1, 0));
      repeat (2) @(posedge core_clk);
      #1 chk("scope", 16'(s), 16'(eng_out.scope));
    end
    $display("test internal mode done");
    eng_in.meas_idle <= 1'b1;
    eng_in.src_ready <= 1'b1;
    eng_in.point_ready <= 1'b1;
    wr(REG_CTRL, ctrl(0, 2, 1, 1));
    wait_rdy(0);
    eng_in.point_ready <= 1'b0;
    n0 = n_rng;
    src.pulse(100 + $urandom % 4901);
    #1 chk("range_go count", 16'(n0 + 1), 16'(n_rng));
    chk("trig_ready_n", 1, 16'(rdy_n));
    eng_in.point_ready <= 1'b1;
    wait_rdy(0);
    wr(REG_CTRL, ctrl(0, 2, 1, 0));
    pol <= 1'b0;
    wr(REG_CTRL, ctrl(0, 2, 0, 1));
    n0 = n_rng;
    src.hold(1);
    repeat (300) @(posedge core_clk);
    src.hold(0);
    repeat (20) @(posedge core_clk);
    #1 chk("retrigger", 1, 16'(n_rng - n0 >= 2));
    $display("test external trigger done");
    wr(REG_CTRL, ctrl(0, 2, 0, 0));
    pol <= 1'b1;
    r = DAC_W'($urandom);
    wr(REG_DAC1, {4'h0, r});
    rd(REG_DAC1, d);
    chk("dac1 staged", {4'h0, r}, d);
    chk("dac1_code", DAC_ZERO, 16'(dac1));
    sweep(1, 0);
    chk("dac1_code", 16'(r), 16'(dac1));
    rd(REG_DACO1, d);
    chk("dac1 applied", {4'h0, r}, d);
    wr(REG_CTRL, ctrl(1, 2, 1, 0));
    r = DAC_W'($urandom);
    wr(REG_DAC2, {4'h0, r});
    sweep(1, 0);
    chk("dac2_code", DAC_ZERO, 16'(dac2));
    sweep(0, 1);
    chk("dac2_code", 16'(r), 16'(dac2));
    wr(REG_CTRL, ctrl(1, 2, 1, 1));
    wr(REG_PRESET, 16'h0001);
    #1 chk("dac1_code", DAC_ZERO, 16'(dac1));
    chk("dac2_code", DAC_ZERO, 16'(dac2));
    rd(REG_CTRL, d);
    chk("ctrl", ctrl(1, 2, 1, 0), d);
    // write while the clock enable is low must be lost
    ce <= 1'b0;
    wr(REG_DAC1, 16'h0123);
    ce <= 1'b1;
    rd(REG_DAC1, d);
    chk("dac1 frozen", 16'(DAC_ZERO), d);
    $display("test converters done");
    for (int i = 0; i < 4; i++) begin
      p0 = n_prs;
      h0 = n_hrd;
      @(posedge core_clk);
      btn_n <= 1'b0;
      repeat (bl[i]) @(posedge core_clk);
      btn_n <= 1'b1;
      repeat (10) @(posedge core_clk);
      #1 chk("btn_press", 16'(p0 + bp[i]), 16'(n_prs));
      chk("hard_reset", 16'(h0 + i / 3), 16'(n_hrd));
    end
    rd(REG_STAT, d);
    chk("stat", 16'((1 << STAT_PRESS_BIT) | (1 << STAT_HARD_BIT)), d);
    rd(REG_STAT, d);
    chk("stat cleared", 16'h0000, d);
    $display("test power button done");
    test_done;
  end

  initial begin
    #200000;
    error_cnt++;
    $display("unexpected watchdog: expected finish seen hang");
    test_done;
  end
endmodule
